/* File: dv/asp_host_model.sv */
// Host side of the audio link: bit clock and frame sync source plus a
// receiver rebuilding 32-bit words from both data lanes.
// Assumes the port is clock slave; bit clock period 125 ns.
`timescale 1ns/1ps
`default_nettype none
module asp_host_model #(
	parameter int HALF = 32
) (
	// Control from the bench
	input wire logic        run,
	input wire logic        lj,
	input wire logic [5:0]  skip,
	// Link
	output logic            bclk,
	output logic            frame_sync,
	input wire logic [1:0]  sd,
	// Received words, lane two in the upper half
	output logic [63:0]     lword,
	output logic [63:0]     rword,
	output int              frames
);
	int bitc;
	int g;

	// Clock stands still while run is low; sync moves on falls
	initial begin
		bclk       = 1'b0;
		frame_sync = 1'b0;
		bitc       = 0;
		frames     = 0;
		forever begin
			#62.5;
			if (run) begin
				bclk = ~bclk;
				if (!bclk) begin
					bitc       = (bitc + 1) % (2 * HALF);
					frame_sync = (bitc < HALF) ? lj : ~lj;
					frames     = frames + int'(bitc == 0);
				end else begin
					// Latch on rising edges, skip counts offset cycles
					g = (bitc - int'(skip) + 2 * HALF) % (2 * HALF);
					for (int l = 0; l < 2; l++) begin
						if (g < HALF)
							lword[l * 32 + 31 - g % HALF] = sd[l];
						else
							rword[l * 32 + 31 - g % HALF] = sd[l];
					end
				end
			end
		end
	end
endmodule : asp_host_model
`default_nettype wire

/* File: dv/asp_port_properties.sv */
// Checker for the audio serial port: bus handshake and link launch timing.
// Assumes it is bound to asp_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module asp_port_properties (
	// Clock and reset
	input wire logic                  pclk,
	input wire logic                  presetn,
	// Register bus
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  pslverr,
	// Link pins
	input wire asp_pkg::asp_pin_in_t  pin_in,
	input wire asp_pkg::asp_pin_out_t pin_out
);
	// ---------------------------------------------------------------
	// Bit clock fall tracker
	// ---------------------------------------------------------------
	logic       bclk_q;
	logic [7:0] since_fall;
	wire logic  fall_seen = bclk_q & ~pin_in.bclk;
	wire logic  cnt_full  = (since_fall == 8'hff);

	// Pclk cycles since the raw bit clock last fell
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_q     <= 1'b0;
			since_fall <= 8'hff;
		end else begin
			bclk_q     <= pin_in.bclk;
			since_fall <= fall_seen ? 8'h00 : since_fall + {7'h00, ~cnt_full};
		end
	end

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence

	a_ready_after_setup: assert property (s_setup |=> s_access)
		else $error("no ready in the access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	a_idle_no_ready: assert property (!psel |-> !pready)
		else $error("ready without select");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag outside the access cycle");
	a_data_on_fall: assert property (
		$changed(pin_out.sdout) && !pin_out.sdout_oe_n |-> since_fall <= 8'd7)
		else $error("data moved away from a bit clock fall");
	a_lane_on_fall: assert property (
		$changed(pin_out.general_output_pin) && !pin_out.general_output_pin_oe_n
		|-> since_fall <= 8'd7) else $error("second lane moved away from a fall");
	a_holder_keeps: assert property (
		pin_out.sdout_keep && pin_out.sdout_oe_n && $past(pin_out.sdout_oe_n)
		|-> $stable(pin_out.sdout)) else $error("held level lost while released");
	a_clock_pins_pair: assert property (
		pin_out.bclk_oe_n == pin_out.frame_sync_oe_n)
		else $error("bit clock and sync drive differ");
endmodule : asp_port_properties

bind asp_port asp_port_properties u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out));
`default_nettype wire

/* File: dv/test_asp_port.sv */
// Self-checking bench for the audio serial port: registers over APB,
// I2S and left-justified streams, second lane, release and idle.
// Assumes the host model as link clock source and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_asp_port;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	localparam logic [127:0] DW = 128'h0ff0_1234_8001_7ffe_3c5a_e187_a5c3_0f96;
	logic                  pclk, presetn, psel, penable, pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata;
	logic                  pready, pslverr, channel_mute;
	logic                  run, lj, bclk_w, fs_w;
	logic [5:0]            skip;
	logic [63:0]           lword, rword;
	int                    frames, failures, total_checks;
	asp_pkg::asp_pin_in_t  pin_in;
	asp_pkg::asp_pin_out_t pin_out;

	assign pin_in = {bclk_w, fs_w, 1'b0};

	asp_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
		.channel_mute(channel_mute));
	asp_host_model host (.run(run), .lj(lj), .skip(skip), .bclk(bclk_w),
		.frame_sync(fs_w), .sd({pin_out.general_output_pin, pin_out.sdout}),
		.lword(lword), .rword(rword), .frames(frames));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer, held until ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			failures++;
	endtask : apb

	task automatic wait_frames(input int n);
		int t;
		t = frames + n;
		while (frames < t)
			@(posedge pclk);
	endtask : wait_frames

	// Program, stream four frames, compare received words
	task automatic stream(input logic [31:0] ctrl, input logic [31:0] slot,
		input logic l, input logic [5:0] s);
		logic [31:0] q;
		logic        e;
		apb(1'b1, 8'h04, slot, q, e);
		apb(1'b1, 8'h00, ctrl, q, e);
		for (int i = 0; i < 4; i++)
			apb(1'b1, 8'h08 + 8'(4 * i), DW[32 * i +: 32], q, e);
		lj   <= l;
		skip <= s;
		run  <= 1'b1;
		wait_frames(4);
		check("left word", {32'h0, lword[31:0]}, {32'h0, DW[31:0]});
		check("right word", {32'h0, rword[31:0]}, {32'h0, DW[63:32]});
		if (ctrl[7]) begin
			check("left lane two", {32'h0, lword[63:32]}, {32'h0, DW[95:64]});
			check("right lane two", {32'h0, rword[63:32]}, {32'h0, DW[127:96]});
		end
		$display("stream test done, control %h", ctrl);
	endtask : stream

	// Count released cycles and driven ones over one frame
	task automatic scan(output int hi, output int ones);
		hi   = 0;
		ones = 0;
		repeat (800) begin
			@(posedge pclk);
			hi   += int'(pin_out.sdout_oe_n);
			ones += int'(!pin_out.sdout_oe_n && pin_out.sdout);
		end
	endtask : scan

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		logic [31:0] q;
		logic        e;
		apb(1'b0, 8'h00, 32'h0, q, e);
		check("control reset", {32'h0, q}, 64'h0000_000d);
		apb(1'b0, 8'h04, 32'h0, q, e);
		check("slot reset", {32'h0, q}, 64'h0000_a080);
		apb(1'b0, 8'h20, 32'h0, q, e);
		check("divider reset", {32'h0, q}, 64'h0000_2020);
		apb(1'b1, 8'h40, 32'hffff_ffff, q, e);
		check("unmapped write error", {63'h0, e}, 64'h1);
		apb(1'b0, 8'h40, 32'h0, q, e);
		check("unmapped read", {31'h0, e, q}, 64'h1_0000_0000);
		$display("register test done");
	endtask : t_regs

	task automatic t_i2s;
		stream(32'h0000_000d, 32'h0000_a080, 1'b0, 6'd1);
	endtask : t_i2s

	task automatic t_i2s_offset;
		stream(32'h0000_100d, 32'h0000_a080, 1'b0, 6'd2);
	endtask : t_i2s_offset

	task automatic t_lj;
		stream(32'h0000_000e, 32'h0000_a080, 1'b1, 6'd0);
	endtask : t_lj

	task automatic t_lj_offset;
		stream(32'h0001_f00e, 32'h0000_a080, 1'b1, 6'd31);
	endtask : t_lj_offset

	task automatic t_lane2;
		stream(32'h0000_008d, 32'ha080_a080, 1'b0, 6'd1);
	endtask : t_lane2

	// Measured frame on the status word, no error or mute at a legal rate
	task automatic t_status;
		logic [31:0] q;
		logic        e;
		apb(1'b1, 8'h00, 32'h0006_000d, q, e);
		wait_frames(2);
		apb(1'b0, 8'h18, 32'h0, q, e);
		check("frame ratio", {52'h0, q[11:0]}, 64'h40);
		check("frame period", {48'h0, q[31:16]}, 64'h320);
		check("clock error and mute", {62'h0, q[12], channel_mute}, 64'h0);
		$display("status test done");
	endtask : t_status

	task automatic t_release;
		logic [31:0] q;
		logic        e;
		int          hi, ones;
		apb(1'b1, 8'h04, 32'h0000_0080, q, e);
		apb(1'b1, 8'h00, 32'h0000_006d, q, e);
		wait_frames(2);
		scan(hi, ones);
		check("released and driven", {62'h0, hi > 0, hi < 800}, 64'h3);
		apb(1'b1, 8'h00, 32'h0000_000d, q, e);
		wait_frames(2);
		scan(hi, ones);
		check("never released", 64'(hi), 64'h0);
		apb(1'b1, 8'h00, 32'h0000_000f, q, e);
		wait_frames(2);
		scan(hi, ones);
		check("reserved framing idle", 64'(hi + ones), 64'h0);
		$display("release test done");
	endtask : t_release

	// ---------------------------------------------------------------
	// Clock, sequence, watchdog, verdict
	// ---------------------------------------------------------------
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		#700us;
		failures++;
		$display("watchdog expired");
		end_sim;
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{run, lj, skip, failures, total_checks} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_i2s;
		t_i2s_offset;
		t_lj;
		t_lj_offset;
		t_lane2;
		t_status;
		t_release;
		end_sim;
	end
endmodule : test_asp_port
`default_nettype wire

/* File: logic/asp_pkg.sv */
// Types for the audio serial port: framing codes, control layout and
// the bundled pin groups. Assumes no other package.
package asp_pkg;

	// Framing select codes
	typedef enum logic [1:0] {
		ASP_TDM  = 2'h0,
		ASP_I2S  = 2'h1,
		ASP_LJ   = 2'h2,
		ASP_RSVD = 2'h3
	} asp_fmt_t;

	// Control register layout
	typedef struct packed {
		logic [12:0] rsvd;
		logic        err_en;
		logic        auto_en;
		logic [4:0]  offset;
		logic        fs_inv;
		logic        bit_clock_invert;
		logic        late;
		logic        daisy;
		logic        lane2;
		logic        hold;
		logic        hiz;
		logic        master;
		logic [1:0]  wlen;
		asp_fmt_t    serial_framing_select;
	} asp_ctrl_t;

	// Raw link inputs
	typedef struct packed {
		logic bclk;
		logic frame_sync;
		logic general_input_pin;
	} asp_pin_in_t;

	// Link outputs with active-low enables
	typedef struct packed {
		logic bclk;
		logic bclk_oe_n;
		logic frame_sync;
		logic frame_sync_oe_n;
		logic sdout;
		logic sdout_oe_n;
		logic general_output_pin;
		logic general_output_pin_oe_n;
		logic sdout_keep;
	} asp_pin_out_t;

endpackage : asp_pkg

/* File: logic/asp_port.sv */
// Audio serial output port, I2S and left-justified multi-slot framing,
// with APB registers and clock auto-detection.
// Assumes pclk at 100 MHz; link pins are asynchronous to pclk.
//
// Summary of operation
// RULE1: I2S left MSB two cycles after sync falls; the code starts it one cycle after, with offset 0
// RULE2: I2S right MSB two cycles after sync rises; the code starts it one cycle after, with offset 0
// RULE3: I2S sync and data launch on falling edge
// RULE4: Frame length covers all active slots
// RULE5: I2S low half left, high half right
// RULE6: LJ high half left, low half right
// RULE7: LJ left MSB with sync rise
// RULE8: LJ right MSB with sync fall
// RULE9: LJ sync launched on falling edge
// RULE10: Host should use offset at high rates
// RULE11: Sixty-four assignable slot positions
// RULE12: Release data line outside owned slots
// RULE13: Bus holder keeps last driven level
// RULE14: Second data lane on general pin
// RULE15: Daisy-chain input on general pin
// RULE16: Late-latch mode delays data launch
// RULE17: Master or slave clocking
// RULE18: Broadcast write triggers every device
// RULE19: Resync aligns sampling across devices
// RULE20: Auto-detect frame rate and clock ratio
// RULE21: Supported rates and ratios, others reserved
// RULE22: Two-bit framing select field
// RULE23: Codes 0-31 left, 32-63 right
// RULE24: Offset delays slot start 0-31 cycles
// RULE25: Unsupported clocks flag error and mute
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"

module asp_port #(
	parameter int NCH = 4
) (
	// APB slave
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Link pins
	input  wire asp_pkg::asp_pin_in_t  pin_in,
	output asp_pkg::asp_pin_out_t      pin_out,
	// Recording mute
	output logic              channel_mute
);

	//--------------------------------------------------------------
	// Constants and helpers
	//--------------------------------------------------------------
	localparam logic [15:0] PER_MIN = 16'(`ASP_CLK_KHZ * 1000 / `ASP_FS_MAX_HZ);
	localparam logic [15:0] PER_MAX = 16'(`ASP_CLK_KHZ * 1000 / `ASP_FS_MIN_HZ);

	function automatic logic [5:0] wbits(input logic [1:0] w);
		unique case (w)
			2'h0: wbits = 6'h10;
			2'h1: wbits = 6'h14;
			2'h2: wbits = 6'h18;
			2'h3: wbits = 6'h20;
		endcase
	endfunction : wbits

	function automatic logic ratio_ok(input logic [11:0] r);
		unique case (r)
			12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060, 12'h080,
			12'h0c0, 12'h100, 12'h180, 12'h200, 12'h400, 12'h800: ratio_ok = 1'b1;
			default: ratio_ok = 1'b0;
		endcase
	endfunction : ratio_ok

	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	asp_pkg::asp_ctrl_t ctrl_reg;
	logic [31:0]        slot_reg;
	logic [31:0]        div_reg;
	logic [31:0]        data_reg [NCH];
	logic [31:0]        shadow_reg [NCH];
	logic               err_reg, short_reg, valid_reg, sync_reg;
	logic [15:0]        per_reg, per_cnt_reg;
	logic [11:0]        ratio_reg, bcnt_reg;

	// Address decode
	wire acc      = psel & penable & pready;
	wire wr       = acc & pwrite;
	wire sel_ctrl = paddr == `ASP_OFF_CTRL;
	wire sel_slot = paddr == `ASP_OFF_SLOT;
	wire sel_stat = paddr == `ASP_OFF_STAT;
	wire sel_bc   = paddr == `ASP_OFF_BCAST;
	wire sel_div  = paddr == `ASP_OFF_DIV;
	wire sel_data = paddr >= `ASP_OFF_DATA0 && paddr <= `ASP_OFF_DATA3 && paddr[1:0] == 2'h0;
	wire [1:0] didx = 2'(paddr[4:2] - 3'h2);
	wire mapped   = sel_ctrl | sel_slot | sel_stat | sel_bc | sel_div | sel_data;
	wire [31:0] stat_w = {per_reg, 1'b0, channel_mute, short_reg, err_reg, ratio_reg};
	wire [31:0] rd_w   = sel_ctrl ? ctrl_reg : sel_slot ? slot_reg : sel_div ? div_reg :
		sel_stat ? stat_w : sel_data ? data_reg[didx] : 32'h0;

	// Control fields
	wire       i2s    = ctrl_reg.serial_framing_select == asp_pkg::ASP_I2S; // see RULE22
	wire       lj     = ctrl_reg.serial_framing_select == asp_pkg::ASP_LJ;
	wire       run    = i2s | lj;
	wire [5:0] wb     = wbits(ctrl_reg.wlen);
	wire [7:0] hdiv   = div_reg[7:0];
	wire [10:0] mhalf = div_reg[18:8];
	wire       resync = wr & sel_bc & pwdata[`ASP_BC_SYNC]; // see RULE18

	// APB answer, one access cycle with no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_w : prdata;
			pslverr <= psel & ~penable & ~mapped;
		end
	end

	// Software-written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `ASP_CTRL_RST;
			slot_reg <= `ASP_SLOT_RST;
			div_reg  <= `ASP_DIV_RST;
			sync_reg <= 1'b0;
			for (int i = 0; i < NCH; i++) data_reg[i] <= 32'h0;
		end else begin
			sync_reg <= resync;
			if (wr & sel_ctrl) ctrl_reg <= pwdata & `ASP_CTRL_WMASK;
			if (wr & sel_slot) slot_reg <= pwdata & `ASP_SLOT_WMASK;
			if (wr & sel_div) div_reg <= pwdata & `ASP_DIV_WMASK;
			if (wr & sel_data) data_reg[didx] <= pwdata;
		end
	end

	//--------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------
	logic [2:0] s1_reg, s2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
		end
	end
	wire bclk_s = s2_reg[2] ^ ctrl_reg.bit_clock_invert;
	wire fs_s   = s2_reg[1] ^ ctrl_reg.fs_inv;
	wire din_s  = s2_reg[0];

	//--------------------------------------------------------------
	// Bit clock edges: own divider or sampled pin
	//--------------------------------------------------------------
	logic [7:0] div_cnt_reg;
	logic       mbclk_reg, bprev_reg;
	wire tick = ctrl_reg.master & (div_cnt_reg >= hdiv - 8'h01);
	wire rise = ctrl_reg.master ? tick & ~mbclk_reg : bclk_s & ~bprev_reg; // see RULE17
	wire fall = ctrl_reg.master ? tick & mbclk_reg : ~bclk_s & bprev_reg;

	// Divider counts in both modes but ticks only in master mode, restarts on resync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_reg <= 8'h0;
			mbclk_reg   <= 1'b0;
			bprev_reg   <= 1'b0;
		end else begin
			bprev_reg   <= bclk_s;
			div_cnt_reg <= (tick | sync_reg) ? 8'h0 : div_cnt_reg + 8'h01; // see RULE19
			if (sync_reg) mbclk_reg <= 1'b0;
			else if (tick) mbclk_reg <= ~mbclk_reg;
		end
	end

	//--------------------------------------------------------------
	// Frame position tracking
	//--------------------------------------------------------------
	logic [10:0] fcnt_reg, hlen_reg;
	logic        fsprev_reg, fsdrv_reg;
	logic [4:0]  bitn_reg, slot_reg_n;
	logic        act_reg;
	// Half of the slot group now running, fixed when the group starts
	logic        half_reg;
	wire         fs_lvl  = ctrl_reg.master ? fsdrv_reg : fs_s;
	wire         fs_chg  = fs_lvl != fsprev_reg;
	wire [10:0]  hlen    = ctrl_reg.master ? mhalf : hlen_reg;
	wire [10:0]  fc1     = fcnt_reg + 11'h001;
	// Predict the half boundary so LJ data leaves with the sync edge
	wire         wrap    = fc1 == hlen;
	wire [10:0]  cyc     = wrap ? 11'h000 : fc1;
	wire         fs_new  = wrap ? ~fsprev_reg : fsprev_reg;
	wire         right_n = i2s ? fs_new : ~fs_new; // see RULE5, RULE6
	// I2S starts one cycle later than LJ, both shifted by the offset
	wire [10:0]  spos    = {6'h0, ctrl_reg.offset} + {10'h0, i2s}; // see RULE1, RULE2, RULE24
	wire         start   = run & (cyc == spos); // see RULE7, RULE8
	wire         lastb   = {1'b0, bitn_reg} == wb - 6'h01;
	// A word runs to its last bit even past the sync change, as the I2S
	// left LSB needs; only a new start or the final slot ends the run.
	// Cutting at the half boundary would drop bits of offset slots.
	wire         act_n   = start | (act_reg & ~(lastb & slot_reg_n == 5'h1f));
	wire [4:0]   bitn_n  = (start | lastb) ? 5'h00 : bitn_reg + 5'h01;
	wire [4:0]   slotn_n = start ? 5'h00 : lastb ? slot_reg_n + 5'h01 : slot_reg_n;
	// Slot code keeps its half until the next start, not the live sync
	wire         half_n  = start ? right_n : half_reg;
	wire [5:0]   code    = {half_n, slotn_n}; // see RULE11, RULE23

	// Sync level and cycle counting on rising edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcnt_reg   <= 11'h0;
			hlen_reg   <= 11'h0;
			fsprev_reg <= 1'b0;
		end else if (sync_reg) begin
			fcnt_reg   <= 11'h0;
			fsprev_reg <= fs_lvl;
		end else if (rise) begin
			fsprev_reg <= fs_lvl;
			fcnt_reg   <= fs_chg ? 11'h0 : (&fcnt_reg ? fcnt_reg : fc1);
			if (fs_chg) hlen_reg <= fc1;
		end
	end

	// Master sync and slot counters move on falling edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fsdrv_reg  <= 1'b0;
			bitn_reg   <= 5'h0;
			slot_reg_n <= 5'h0;
			act_reg    <= 1'b0;
			half_reg   <= 1'b0;
		end else if (sync_reg) begin
			fsdrv_reg <= 1'b0;
			act_reg   <= 1'b0;
		end else if (fall) begin
			if (ctrl_reg.master & wrap) fsdrv_reg <= ~fsdrv_reg; // see RULE3, RULE9
			bitn_reg   <= bitn_n;
			slot_reg_n <= slotn_n;
			act_reg    <= act_n;
			// Half flag follows the group, see RULE1, RULE2
			half_reg   <= half_n;
		end
	end

	//--------------------------------------------------------------
	// Slot ownership and serial bit selection
	//--------------------------------------------------------------
	logic [NCH-1:0] own, bitv, inhalf;
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			wire [7:0] sf = slot_reg[8*g +: 8];
			assign own[g]    = act_n & sf[`ASP_SLOT_EN] & (sf[5:0] == code);
			assign bitv[g]   = shadow_reg[g][5'h1f - bitn_n];
			assign inhalf[g] = sf[`ASP_SLOT_EN] & (sf[5] == (i2s ? fsprev_reg : ~fsprev_reg));
		end
	endgenerate

	// Lane split: channels 2 and 3 move to the second lane
	wire [NCH-1:0] lmask = ctrl_reg.lane2 ? NCH'(3) : {NCH{1'b1}};
	wire [NCH-1:0] own1  = own & lmask; // see RULE14
	wire [NCH-1:0] own2  = own & ~lmask;
	wire d1 = |(own1 & bitv) & ~channel_mute;
	wire d2 = |(own2 & bitv) & ~channel_mute;
	// Unowned slots forward the chained device or release the line
	wire fwd   = ctrl_reg.daisy & ~|own1; // see RULE15
	wire drv1  = |own1 | fwd | ~ctrl_reg.hiz; // see RULE12
	wire drv2  = |own2 | ~ctrl_reg.hiz;
	wire val1  = |own1 ? d1 : fwd ? din_s : (ctrl_reg.hiz ? pin_out.sdout : 1'b0); // see RULE13
	wire val2  = |own2 ? d2 : (ctrl_reg.hiz ? pin_out.general_output_pin : 1'b0);

	// Staged bit for late-latch launch on the next rising edge
	logic [3:0] stage_reg;
	wire  out_en = ctrl_reg.late ? rise : fall; // see RULE16
	wire [3:0] out_w = ctrl_reg.late ? stage_reg : {val1, ~drv1, val2, ~drv2};

	// Latch a frame of samples at the left-half start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg <= 4'h5;
			for (int i = 0; i < NCH; i++) shadow_reg[i] <= 32'h0;
		end else if (fall) begin
			stage_reg <= {val1, ~drv1, val2, ~drv2};
			if (start & ~right_n)
				for (int i = 0; i < NCH; i++) shadow_reg[i] <= data_reg[i];
		end
	end

	// Pin registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= '{default: 1'b1, bclk: 1'b0, frame_sync: 1'b0, sdout: 1'b0,
				general_output_pin: 1'b0, sdout_keep: 1'b0};
		end else begin
			pin_out.bclk            <= (ctrl_reg.master & (tick ? ~mbclk_reg : mbclk_reg))
				^ ctrl_reg.bit_clock_invert;
			pin_out.bclk_oe_n       <= ~ctrl_reg.master;
			pin_out.frame_sync      <= (ctrl_reg.master & fall & wrap ? ~fsdrv_reg : fsdrv_reg)
				^ ctrl_reg.fs_inv;
			pin_out.frame_sync_oe_n <= ~ctrl_reg.master;
			pin_out.sdout_keep      <= ctrl_reg.hiz & ctrl_reg.hold;
			// Idle framing: lines low, or held when released
			if (~run) begin
				pin_out.sdout                   <= ctrl_reg.hiz & pin_out.sdout;
				pin_out.general_output_pin      <= ctrl_reg.hiz & pin_out.general_output_pin;
				pin_out.sdout_oe_n              <= ctrl_reg.hiz;
				pin_out.general_output_pin_oe_n <= ~ctrl_reg.lane2 | ctrl_reg.hiz;
			end else if (out_en) begin
				pin_out.sdout                   <= out_w[3];
				pin_out.sdout_oe_n              <= out_w[2];
				pin_out.general_output_pin      <= out_w[1];
				pin_out.general_output_pin_oe_n <= ~ctrl_reg.lane2 | out_w[0];
			end
		end
	end

	//--------------------------------------------------------------
	// Clock auto-detection and error flags
	//--------------------------------------------------------------
	wire [2:0]  nhalf  = 3'(inhalf[0]) + 3'(inhalf[1]) + 3'(inhalf[2]) + 3'(inhalf[3]);
	wire [8:0]  need   = 9'(nhalf * wb);
	wire        shortv = run & rise & fs_chg & ({2'h0, need} > fc1); // see RULE4, RULE5, RULE6
	wire        fstart = rise & fs_chg & (i2s ? ~fs_lvl : fs_lvl);
	wire [31:0] rk     = 32'(ratio_reg) * `ASP_CLK_KHZ;
	wire        bclk_ok = rk <= 32'(per_reg) * `ASP_BCLK_MAX_KHZ
		&& rk >= 32'(per_reg) * `ASP_BCLK_MIN_KHZ;
	wire        rate_ok = per_reg >= PER_MIN && per_reg <= PER_MAX;
	// Lost sync counts as unsupported once the counter runs out
	wire        bad    = valid_reg & ~(ratio_ok(ratio_reg) & rate_ok & bclk_ok) | &per_cnt_reg;
	wire        errv   = ctrl_reg.auto_en & bad; // see RULE21
	wire        clr    = wr & sel_stat;

	// Measure pclk per frame and bit clocks per frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_reg  <= 16'h0;
			per_reg      <= 16'h0;
			bcnt_reg     <= 12'h0;
			ratio_reg    <= 12'h0;
			valid_reg    <= 1'b0;
			err_reg      <= 1'b0;
			short_reg    <= 1'b0;
			channel_mute <= 1'b0;
		end else begin
			per_cnt_reg <= fstart ? 16'h1 : (&per_cnt_reg ? per_cnt_reg : per_cnt_reg + 16'h1);
			if (fstart) begin
				per_reg   <= per_cnt_reg; // see RULE20
				ratio_reg <= bcnt_reg;
				valid_reg <= 1'b1;
			end
			if (rise) bcnt_reg <= fstart ? 12'h1 : (&bcnt_reg ? bcnt_reg : bcnt_reg + 12'h1);
			// Sticky flags: a new event wins over the clear
			err_reg      <= (errv & ctrl_reg.err_en) | (err_reg & ~(clr & pwdata[`ASP_ST_ERR]));
			short_reg    <= shortv | (short_reg & ~(clr & pwdata[`ASP_ST_SHORT]));
			channel_mute <= errv & ctrl_reg.err_en; // see RULE25
		end
	end

endmodule : asp_port
`default_nettype wire

/* File: logic/asp_regs.svh */
// Register offsets, field positions, reset values and timing for the
// audio serial port. Assumes inclusion from the port module only.
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

// Byte offsets on the APB register bus
`define ASP_OFF_CTRL   8'h00
`define ASP_OFF_SLOT   8'h04
`define ASP_OFF_DATA0  8'h08
`define ASP_OFF_DATA3  8'h14
`define ASP_OFF_STAT   8'h18
`define ASP_OFF_BCAST  8'h1c
`define ASP_OFF_DIV    8'h20

// Reset values and writable masks
`define ASP_CTRL_RST   32'h0000_000d
`define ASP_CTRL_WMASK 32'h0007_ffff
`define ASP_SLOT_RST   32'h0000_a080
`define ASP_SLOT_WMASK 32'hbfbf_bfbf
`define ASP_DIV_RST    32'h0000_2020
`define ASP_DIV_WMASK  32'h0007_ffff

// Field positions
`define ASP_SLOT_EN    7
`define ASP_ST_ERR     12
`define ASP_ST_SHORT   13
`define ASP_BC_SYNC    0

// Timing figures
`define ASP_CLK_KHZ      100000
`define ASP_FS_MIN_HZ    7350
`define ASP_FS_MAX_HZ    768000
`define ASP_BCLK_MAX_KHZ 24576
`define ASP_BCLK_MIN_KHZ 256

`endif
